// file: inc/dmem_pkg.sv
package dmem_pkg;
	// ==========================================================
	// Memory layout
	localparam int ram_bytes = 192;
	localparam logic [7:0] ctl_base = 8'hC0;
	localparam logic [7:0] ctl_last = 8'hFF;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] a_port_a_data = 8'hC0;
	localparam logic [7:0] a_port_a_dir = 8'hC1;
	localparam logic [7:0] a_port_b_data = 8'hC2;
	localparam logic [7:0] a_port_b_dir = 8'hC3;
	localparam logic [7:0] a_port_c_data = 8'hC4;
	localparam logic [7:0] a_port_c_dir = 8'hC5;
	localparam logic [7:0] a_port_d_data = 8'hC6;
	localparam logic [7:0] a_port_d_dir = 8'hC7;
	localparam logic [7:0] a_port_a_func = 8'hCA;
	localparam logic [7:0] a_port_b_func = 8'hCB;
	localparam logic [7:0] a_pullup = 8'hCC;
	localparam logic [7:0] a_tm0 = 8'hD0;
	localparam logic [7:0] a_t0 = 8'hD1;
	localparam logic [7:0] a_tm1 = 8'hD2;
	localparam logic [7:0] a_t1w = 8'hD3;
	localparam logic [7:0] a_t1r = 8'hD4;
	localparam logic [7:0] a_pwm0_hi = 8'hD5;
	localparam logic [7:0] a_tm2 = 8'hD6;
	localparam logic [7:0] a_t2 = 8'hD7;
	localparam logic [7:0] a_tm3 = 8'hD8;
	localparam logic [7:0] a_t3w = 8'hD9;
	localparam logic [7:0] a_t3r = 8'hDA;
	localparam logic [7:0] a_pwm1_hi = 8'hDB;
	localparam logic [7:0] a_buzzer = 8'hDE;
	localparam logic [7:0] a_serial_mode = 8'hE0;
	localparam logic [7:0] a_serial_data = 8'hE1;
	localparam logic [7:0] a_ien_h = 8'hE2;
	localparam logic [7:0] a_ien_l = 8'hE3;
	localparam logic [7:0] a_irq_h = 8'hE4;
	localparam logic [7:0] a_irq_l = 8'hE5;
	localparam logic [7:0] a_edge_sel = 8'hE6;
	localparam logic [7:0] a_adc_mode = 8'hEA;
	localparam logic [7:0] a_adc_result = 8'hEB;
	localparam logic [7:0] a_basic_timer = 8'hEC;
	localparam logic [7:0] a_watchdog = 8'hED;
	localparam logic [7:0] a_power_fail = 8'hEF;
	// ==========================================================
	// Reset values
	localparam logic [7:0] rst_zero = 8'h00;
	localparam logic [7:0] rst_ones = 8'hFF;
	localparam logic [7:0] rst_serial_mode = 8'h01;
	localparam logic [7:0] rst_adc_mode = 8'h01;
	localparam logic [7:0] rst_clock_ctl = 8'h17;
	localparam logic [7:0] rst_watchdog = 8'h7F;
	// ==========================================================
	// Mode fields in the timer mode registers
	localparam int cap_bit = 4;
	localparam int cap0_bit = 5;
	localparam int pwm_en_bit = 5;
	// ==========================================================
	// Bit operation codes
	localparam logic [1:0] op_byte = 2'h0;
	localparam logic [1:0] op_set = 2'h1;
	localparam logic [1:0] op_clr = 2'h2;
	// ==========================================================
	// Timer view of a shared address
	typedef enum logic [2:0] {
		view_timer = 3'b001,
		view_capture = 3'b010,
		view_pwm = 3'b100
	} view_t;
endpackage : dmem_pkg

// file: hw/dmem_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] Data memory splits into user RAM with stack and a control register window.
// [RULE2] 192 bytes of eight-bit read/write RAM at the bottom of data memory.
// [RULE3] Control registers decode only at addresses 0C0 through 0FF.
// [RULE4] Unassigned window addresses read arbitrary data; writes do nothing defined.
// [RULE5] Software writes write-only registers with whole-byte stores only.
// [RULE6] Bit/byte registers accept single-bit set or clear touching only that bit.
// [RULE7] Byte-only registers get plain byte writes, no read-modify-write.
// [RULE8] One address selects different registers by direction and timer mode.
// [RULE9] D1H reads count or capture of timer 0; writes timer 0 compare data.
// [RULE10] D3H writes timer1 data or PWM0 period; D4H reads count/capture/duty.
// [RULE11] D7H reads count or capture of timer 2; writes timer 2 compare data.
// [RULE12] D9H writes timer3 data or PWM1 period; DAH reads count/capture/duty.
// [RULE13] ECH reads basic timer count; writes clock and basic timer control.
// [RULE14] Each access completes in one clock; reset loads documented values.
module dmem_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// CPU data bus
	input wire logic [7:0] addr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [1:0] wr_op,
	input wire logic [2:0] wr_bit,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	// Live peripheral state
	input wire logic [7:0] timer0_count,
	input wire logic [7:0] timer0_capture,
	input wire logic [7:0] timer1_count,
	input wire logic [7:0] timer1_capture,
	input wire logic [7:0] timer2_count,
	input wire logic [7:0] timer2_capture,
	input wire logic [7:0] timer3_count,
	input wire logic [7:0] timer3_capture,
	input wire logic [7:0] adc_result,
	input wire logic [7:0] basic_timer_count,
	input wire logic [7:0] watchdog_count,
	// Control outputs
	output logic [7:0] timer0_mode,
	output logic [7:0] timer0_data,
	output logic [7:0] timer1_mode,
	output logic [7:0] timer1_data,
	output logic [7:0] pwm0_period,
	output logic [7:0] pwm0_duty,
	output logic [7:0] timer2_mode,
	output logic [7:0] timer2_data,
	output logic [7:0] timer3_mode,
	output logic [7:0] timer3_data,
	output logic [7:0] pwm1_period,
	output logic [7:0] pwm1_duty,
	output logic [7:0] clock_timer_control,
	output logic [7:0] watchdog_control,
	output logic watchdog_write
);

	// ==========================================================
	// Storage
	logic [7:0] ram_q [dmem_pkg::ram_bytes];
	logic [7:0] regs_q [dmem_pkg::ctl_base:dmem_pkg::ctl_last];
	logic [7:0] t0_data_q;
	logic [7:0] t1_data_q;
	logic [7:0] p0_per_q;
	logic [7:0] p0_duty_q;
	logic [7:0] t2_data_q;
	logic [7:0] t3_data_q;
	logic [7:0] p1_per_q;
	logic [7:0] p1_duty_q;
	logic [7:0] ckctl_q;
	logic [7:0] wdt_q;
	logic wdt_wr_q;
	logic [7:0] rd_q;
	logic is_ram;
	logic [7:0] cur;
	logic [7:0] merged;
	logic bit_ok;
	dmem_pkg::view_t v0, v1, v2, v3;

	// ==========================================================
	// Mode decode per timer
	function automatic dmem_pkg::view_t view_of(input logic [7:0] m, input int capb,
			input logic pwm_able);
		dmem_pkg::view_t v;
		v = dmem_pkg::view_timer;
		if (pwm_able && m[dmem_pkg::pwm_en_bit]) begin
			v = dmem_pkg::view_pwm;
		end else if (m[capb]) begin
			v = dmem_pkg::view_capture;
		end
		return v;
	endfunction : view_of

	always_comb begin
		v0 = view_of(regs_q[dmem_pkg::a_tm0], dmem_pkg::cap0_bit, 1'b0); // [RULE8]
		v1 = view_of(regs_q[dmem_pkg::a_tm1], dmem_pkg::cap_bit, 1'b1); // [RULE8]
		v2 = view_of(regs_q[dmem_pkg::a_tm2], dmem_pkg::cap0_bit, 1'b0); // [RULE8]
		v3 = view_of(regs_q[dmem_pkg::a_tm3], dmem_pkg::cap_bit, 1'b1); // [RULE8]
	end

	// ==========================================================
	// Address split and bit merge
	always_comb begin
		is_ram = addr < 8'(dmem_pkg::ram_bytes); // [RULE1] [RULE2]
		cur = is_ram ? ram_q[addr] : regs_q[addr];
		bit_ok = 1'b1;
		unique case (addr)
			dmem_pkg::a_port_a_func, dmem_pkg::a_port_b_func, dmem_pkg::a_pullup,
			dmem_pkg::a_t0, dmem_pkg::a_t1w, dmem_pkg::a_t1r, dmem_pkg::a_pwm0_hi,
			dmem_pkg::a_t2, dmem_pkg::a_t3w, dmem_pkg::a_t3r, dmem_pkg::a_pwm1_hi,
			dmem_pkg::a_buzzer, dmem_pkg::a_adc_result, dmem_pkg::a_basic_timer,
			dmem_pkg::a_watchdog, dmem_pkg::a_power_fail,
			dmem_pkg::a_port_a_dir, dmem_pkg::a_port_b_dir,
			dmem_pkg::a_port_c_dir, dmem_pkg::a_port_d_dir: begin
				bit_ok = 1'b0;
			end
			default: begin
				bit_ok = 1'b1;
			end
		endcase
		merged = wr_data;
		// Byte-only registers treat a bit op as a byte store; software must not rely on it
		if (bit_ok && wr_op == dmem_pkg::op_set) begin
			merged = cur | (8'h01 << wr_bit); // [RULE6]
		end else if (bit_ok && wr_op == dmem_pkg::op_clr) begin
			merged = cur & ~(8'h01 << wr_bit); // [RULE6]
		end
	end

	// ==========================================================
	// User RAM, not reset
	always_ff @(posedge clock) begin
		if (wr_en && is_ram) begin
			ram_q[addr] <= merged; // [RULE2] [RULE14]
		end
	end

	// ==========================================================
	// Plain control registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = dmem_pkg::ctl_base; i <= dmem_pkg::ctl_last; i++) begin
				regs_q[i] <= dmem_pkg::rst_zero; // [RULE14]
			end
			regs_q[dmem_pkg::a_buzzer] <= dmem_pkg::rst_ones;
			regs_q[dmem_pkg::a_serial_mode] <= dmem_pkg::rst_serial_mode;
			regs_q[dmem_pkg::a_adc_mode] <= dmem_pkg::rst_adc_mode;
		end else if (wr_en && !is_ram) begin
			unique case (addr)
				dmem_pkg::a_t0, dmem_pkg::a_t1w, dmem_pkg::a_t1r, dmem_pkg::a_t2,
				dmem_pkg::a_t3w, dmem_pkg::a_t3r, dmem_pkg::a_basic_timer,
				dmem_pkg::a_watchdog, dmem_pkg::a_adc_result: begin
				end
				default: begin
					regs_q[addr] <= merged; // [RULE3] [RULE4]
				end
			endcase
		end
	end

	// ==========================================================
	// Timer 0 and 2 compare data
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			t0_data_q <= dmem_pkg::rst_ones;
			t2_data_q <= dmem_pkg::rst_ones;
		end else if (wr_en) begin
			if (addr == dmem_pkg::a_t0) begin
				t0_data_q <= wr_data; // [RULE9] [RULE5]
			end
			if (addr == dmem_pkg::a_t2) begin
				t2_data_q <= wr_data; // [RULE11] [RULE7]
			end
		end
	end

	// ==========================================================
	// Timer 1 / PWM0 and timer 3 / PWM1 write side
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			t1_data_q <= dmem_pkg::rst_ones;
			p0_per_q <= dmem_pkg::rst_ones;
			p0_duty_q <= dmem_pkg::rst_zero;
			t3_data_q <= dmem_pkg::rst_ones;
			p1_per_q <= dmem_pkg::rst_ones;
			p1_duty_q <= dmem_pkg::rst_zero;
		end else if (wr_en) begin
			if (addr == dmem_pkg::a_t1w) begin
				if (v1 == dmem_pkg::view_pwm) begin
					p0_per_q <= wr_data; // [RULE10]
				end else begin
					t1_data_q <= wr_data; // [RULE10]
				end
			end
			// Duty only loads in PWM mode; other modes ignore the write
			if (addr == dmem_pkg::a_t1r && v1 == dmem_pkg::view_pwm) begin
				p0_duty_q <= wr_data; // [RULE10]
			end
			if (addr == dmem_pkg::a_t3w) begin
				if (v3 == dmem_pkg::view_pwm) begin
					p1_per_q <= wr_data; // [RULE12]
				end else begin
					t3_data_q <= wr_data; // [RULE12]
				end
			end
			if (addr == dmem_pkg::a_t3r && v3 == dmem_pkg::view_pwm) begin
				p1_duty_q <= wr_data; // [RULE12]
			end
		end
	end

	// ==========================================================
	// Clock control and watchdog write side
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ckctl_q <= dmem_pkg::rst_clock_ctl;
			wdt_q <= dmem_pkg::rst_watchdog;
			wdt_wr_q <= 1'b0;
		end else begin
			wdt_wr_q <= wr_en && addr == dmem_pkg::a_watchdog;
			if (wr_en && addr == dmem_pkg::a_basic_timer) begin
				ckctl_q <= wr_data; // [RULE13]
			end
			if (wr_en && addr == dmem_pkg::a_watchdog) begin
				wdt_q <= wr_data;
			end
		end
	end

	// ==========================================================
	// Read side, registered so data appears the cycle after the strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= dmem_pkg::rst_zero;
		end else if (rd_en) begin
			if (is_ram) begin
				rd_q <= ram_q[addr]; // [RULE14]
			end else begin
				unique case (addr)
					dmem_pkg::a_t0: begin
						rd_q <= (v0 == dmem_pkg::view_capture) ? timer0_capture
								: timer0_count; // [RULE9]
					end
					dmem_pkg::a_t1r: begin
						unique case (v1)
							dmem_pkg::view_capture: rd_q <= timer1_capture; // [RULE10]
							dmem_pkg::view_pwm: rd_q <= p0_duty_q; // [RULE10]
							default: rd_q <= timer1_count; // [RULE10]
						endcase
					end
					dmem_pkg::a_t2: begin
						rd_q <= (v2 == dmem_pkg::view_capture) ? timer2_capture
								: timer2_count; // [RULE11]
					end
					dmem_pkg::a_t3r: begin
						unique case (v3)
							dmem_pkg::view_capture: rd_q <= timer3_capture; // [RULE12]
							dmem_pkg::view_pwm: rd_q <= p1_duty_q; // [RULE12]
							default: rd_q <= timer3_count; // [RULE12]
						endcase
					end
					dmem_pkg::a_basic_timer: rd_q <= basic_timer_count; // [RULE13]
					dmem_pkg::a_adc_result: rd_q <= adc_result;
					dmem_pkg::a_watchdog: rd_q <= watchdog_count;
					dmem_pkg::a_t1w, dmem_pkg::a_t3w: rd_q <= dmem_pkg::rst_zero;
					default: rd_q <= regs_q[addr]; // [RULE3] [RULE4]
				endcase
			end
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data = rd_q;
	assign timer0_mode = regs_q[dmem_pkg::a_tm0];
	assign timer1_mode = regs_q[dmem_pkg::a_tm1];
	assign timer2_mode = regs_q[dmem_pkg::a_tm2];
	assign timer3_mode = regs_q[dmem_pkg::a_tm3];
	assign timer0_data = t0_data_q;
	assign timer1_data = t1_data_q;
	assign pwm0_period = p0_per_q;
	assign pwm0_duty = p0_duty_q;
	assign timer2_data = t2_data_q;
	assign timer3_data = t3_data_q;
	assign pwm1_period = p1_per_q;
	assign pwm1_duty = p1_duty_q;
	assign clock_timer_control = ckctl_q;
	assign watchdog_control = wdt_q;
	assign watchdog_write = wdt_wr_q;

endmodule : dmem_regs

// file: verification/dmem_regs_assertions.sv
`timescale 1ns/10ps
// ==========================
// Bus properties of the register bank
module dmem_regs_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// CPU data bus
	input wire logic [7:0] addr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	// Live state
	input wire logic [7:0] timer0_count,
	input wire logic [7:0] basic_timer_count,
	// Register outputs
	input wire logic [7:0] timer0_mode,
	input wire logic [7:0] timer0_data,
	input wire logic [7:0] timer1_mode,
	input wire logic [7:0] timer1_data,
	input wire logic [7:0] pwm0_period,
	input wire logic [7:0] pwm0_duty,
	input wire logic [7:0] clock_timer_control,
	input wire logic watchdog_write
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	t0_load_a:
	assert property (wr_en && addr == dmem_pkg::a_t0 |=> timer0_data == $past(wr_data))
		else $error("timer0 data not loaded");
	t0_view_a:
	assert property (rd_en && addr == dmem_pkg::a_t0 && !timer0_mode[dmem_pkg::cap0_bit]
		|=> rd_data == $past(timer0_count))
		else $error("timer0 count not read");
	pwm_period_a:
	assert property (wr_en && addr == dmem_pkg::a_t1w && timer1_mode[dmem_pkg::pwm_en_bit]
		|=> pwm0_period == $past(wr_data) && $stable(timer1_data))
		else $error("pwm0 period write wrong");
	duty_guard_a:
	assert property (wr_en && addr == dmem_pkg::a_t1r && !timer1_mode[dmem_pkg::pwm_en_bit]
		|=> $stable(pwm0_duty))
		else $error("pwm0 duty written outside pwm mode");
	bt_view_a:
	assert property (rd_en && addr == dmem_pkg::a_basic_timer
		|=> rd_data == $past(basic_timer_count))
		else $error("basic timer count not read");
	ckctl_load_a:
	assert property (wr_en && addr == dmem_pkg::a_basic_timer
		|=> clock_timer_control == $past(wr_data))
		else $error("clock control not loaded");
	rd_hold_a:
	assert property (!rd_en |=> $stable(rd_data))
		else $error("read data moved without a read");
	wd_pulse_a:
	assert property (watchdog_write == $past(wr_en && addr == dmem_pkg::a_watchdog))
		else $error("watchdog pulse wrong");
endmodule : dmem_regs_assertions

bind dmem_regs dmem_regs_assertions chk_i (.clock(clock), .rst_b(rst_b), .addr(addr),
	.rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
	.timer0_count(timer0_count), .basic_timer_count(basic_timer_count),
	.timer0_mode(timer0_mode), .timer0_data(timer0_data), .timer1_mode(timer1_mode),
	.timer1_data(timer1_data), .pwm0_period(pwm0_period), .pwm0_duty(pwm0_duty),
	.clock_timer_control(clock_timer_control), .watchdog_write(watchdog_write));

// file: verification/cpu_model.sv
`timescale 1ns/10ps
// ==========================
// CPU side of the data bus
module cpu_model (
	// Clock
	input wire logic clock,
	// Requests
	output logic [7:0] addr,
	output logic rd_en,
	output logic wr_en,
	output logic [1:0] wr_op,
	output logic [2:0] wr_bit,
	output logic [7:0] wr_data,
	// Answer
	input wire logic [7:0] rd_data
);
	initial begin
		{addr, rd_en, wr_en, wr_op, wr_bit, wr_data} = '0;
	end
	// Idle bus shows inverted values so a stale request never looks valid
	task automatic access(input logic w, input logic [7:0] a, input logic [1:0] op,
			input logic [2:0] b, input logic [7:0] d, output logic [7:0] q);
		@(posedge clock);
		addr <= a;
		rd_en <= !w;
		wr_en <= w;
		wr_op <= op;
		wr_bit <= b;
		wr_data <= d;
		@(posedge clock);
		addr <= ~a;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		wr_data <= ~d;
		#1 q = rd_data;
	endtask : access
endmodule : cpu_model

// file: verification/data_memory_control_register_map_tb_top.sv
`timescale 1ns/10ps
// ==========================
// Register bank bench
module data_memory_control_register_map_tb_top;
	logic clock;
	logic rst_b;
	logic rd_en;
	logic wr_en;
	logic watchdog_write;
	logic [1:0] wr_op;
	logic [2:0] wr_bit;
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] q;
	logic [7:0] x;
	logic [7:0] y;
	logic [7:0] live [11];
	logic [7:0] m [256];
	logic [7:0] ed [4];
	logic [7:0] ep [4];
	logic [7:0] eu [4];
	logic [7:0] ra [9] = '{8'hC1, 8'hC3, 8'hD0, 8'hD6, 8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hEA};
	wire logic [7:0] o [14];
	int mismatches;
	int n_checks;
	int cyc;
	int mi;
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	dmem_regs dut (.clock(clock), .rst_b(rst_b), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
		.wr_op(wr_op), .wr_bit(wr_bit), .wr_data(wr_data), .rd_data(rd_data),
		.timer0_count(live[0]), .timer0_capture(live[1]), .timer1_count(live[2]),
		.timer1_capture(live[3]), .timer2_count(live[4]), .timer2_capture(live[5]),
		.timer3_count(live[6]), .timer3_capture(live[7]), .adc_result(live[8]),
		.basic_timer_count(live[9]), .watchdog_count(live[10]), .timer0_mode(o[0]),
		.timer0_data(o[1]), .timer1_mode(o[2]), .timer1_data(o[3]), .pwm0_period(o[4]),
		.pwm0_duty(o[5]), .timer2_mode(o[6]), .timer2_data(o[7]), .timer3_mode(o[8]),
		.timer3_data(o[9]), .pwm1_period(o[10]), .pwm1_duty(o[11]),
		.clock_timer_control(o[12]), .watchdog_control(o[13]), .watchdog_write(watchdog_write));
	cpu_model cpu (.clock(clock), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_op(wr_op),
		.wr_bit(wr_bit), .wr_data(wr_data), .rd_data(rd_data));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input logic [1:0] op = dmem_pkg::op_byte, input logic [2:0] b = 3'h0);
		cpu.access(1'b1, a, op, b, d, q);
		// Duty registers ignore writes outside pwm mode
		if ((a == 8'hD4 && !m[8'hD2][5]) || (a == 8'hDA && !m[8'hD8][5])) return;
		if (op == dmem_pkg::op_set) m[a][b] = 1'b1;
		else if (op == dmem_pkg::op_clr) m[a][b] = 1'b0;
		else m[a] = d;
	endtask : wr
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			8'hD1: return m[8'hD0][5] ? live[1] : live[0];
			8'hD4: return m[8'hD2][5] ? m[a] : (m[8'hD2][4] ? live[3] : live[2]);
			8'hD7: return m[8'hD6][5] ? live[5] : live[4];
			8'hDA: return m[8'hD8][5] ? m[a] : (m[8'hD8][4] ? live[7] : live[6]);
			8'hEB: return live[8];
			8'hEC: return live[9];
			8'hED: return live[10];
			default: return m[a];
		endcase
	endfunction : exp_rd
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		foreach (live[i]) live[i] <= 8'($urandom);
		cpu.access(1'b0, a, dmem_pkg::op_byte, 3'h0, 8'h00, q);
		chk(q, exp_rd(a));
	endtask : rd
	task automatic final_report;
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			$display("MISMATCH %0t timeout", $time);
			final_report;
		end
	end
	initial begin
		rst_b = 1'b0;
		foreach (live[i]) live[i] = 8'h00;
		foreach (m[i]) m[i] = 8'h00;
		foreach (ed[i]) begin
			ed[i] = 8'hFF;
			ep[i] = 8'hFF;
			eu[i] = 8'h00;
		end
		m[8'hE0] = 8'h01;
		m[8'hEA] = 8'h01;
		void'($urandom(4145));
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		chk({o[0], o[1], o[2], o[3], o[4], o[5], o[6], o[7]},
			64'h00FF_00FF_FF00_00FF);
		chk({o[8], o[9], o[10], o[11], o[12], o[13], rd_data, 7'h00, watchdog_write},
			64'h00FF_FF00_177F_0000);
		foreach (ra[i]) rd(ra[i]);
		for (int i = 0; i < 24; i++) begin
			x = (i == 0) ? 8'h00 : ((i == 1) ? 8'hBF : 8'($urandom_range(191)));
			wr(x, 8'($urandom));
			rd(x);
		end
		wr(8'hC0, 8'h5A);
		rd(8'h00);
		rd(8'hC0);
		// RAM is not reset, and bit ops go only to bit-addressable targets
		wr(8'h10, 8'h00);
		wr(8'hC0, 8'hFF);
		for (int b = 0; b < 8; b++) begin
			wr(8'h10, 8'h00, dmem_pkg::op_set, 3'(b));
			wr(8'hC0, 8'h00, dmem_pkg::op_clr, 3'(b));
			rd(8'h10);
			rd(8'hC0);
		end
		// Every timer through timer and capture views; timers 1 and 3 also through pwm view
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 3; k++) begin
				mi = t * 2 + ((t > 1) ? 2 : 0);
				y = 8'(k * 16);
				x = 8'($urandom);
				wr(8'hD0 + 8'(mi), y);
				wr(8'hD1 + 8'(mi), x);
				if (t % 2 == 0 || !y[5]) ed[t] = x;
				else ep[t] = x;
				if (t % 2 == 1) begin
					x = 8'($urandom);
					wr(8'hD2 + 8'(mi), x);
					if (y[5]) eu[t] = x;
					chk({o[mi + 2], o[mi + 3]}, {ep[t], eu[t]});
				end
				chk({o[mi], o[mi + 1]}, {y, ed[t]});
				rd(8'hD1 + 8'(mi + t % 2));
			end
		end
		x = 8'($urandom);
		wr(8'hEC, x);
		chk(o[12], x);
		rd(8'hEC);
		rd(8'hEB);
		wr(8'hED, x);
		chk({o[13], 7'h00, watchdog_write}, {x, 8'h01});
		rd(8'hED);
		wr(8'hDE, 8'h0F);
		wr(8'hC8, x);
		final_report;
	end
endmodule : data_memory_control_register_map_tb_top
